// >>> hw/deformatter_cmd_pkg.sv
// package: function codes, counts, sizes and carriers for the deformatter command handler
package deformatter_cmd_pkg;
  localparam logic [7:0]  FC_GENERAL_STATUS   = 8'h61;
  localparam logic [7:0]  FC_HEADER_REQUEST   = 8'h62;
  localparam logic [7:0]  FC_START_OBSERVE    = 8'h30;
  localparam logic [7:0]  FC_TIME_REFERENCE   = 8'h41;
  localparam logic [7:0]  FC_MODEL_LIMIT      = 8'h66;
  localparam logic [7:0]  FC_SINGLE_HEADER    = 8'h67;
  localparam logic [7:0]  FC_TRACK_STATUS     = 8'h68;
  localparam logic [7:0]  FC_SPECIAL_STATUS   = 8'h69;
  localparam logic [7:0]  FC_SELF_TEST        = 8'h70;
  localparam logic [7:0]  FC_DRIVE_TEST       = 8'h71;
  localparam logic [7:0]  FC_PATTERN_LOAD     = 8'h72;
  localparam logic [7:0]  FC_TEST_CYCLE       = 8'h73;
  localparam logic [7:0]  FC_SYNC_ENABLE      = 8'h74;
  localparam logic [7:0]  FC_ERROR_DISPLAY    = 8'h75;
  localparam logic [7:0]  FC_TRACK_WRITE      = 8'h80;
  localparam logic [7:0]  FC_TRACK_READ       = 8'h81;
  localparam logic [7:0]  FC_TRACK_RESET      = 8'h82;
  localparam logic [10:0] MODEL_LIMIT_LEN     = 11'd6;
  localparam logic [10:0] HEADER_LEN          = 11'd30;
  localparam logic [10:0] TRACK_STATUS_LEN    = 11'd72;
  localparam logic [10:0] GENERAL_STATUS_LEN  = 11'd7;
  localparam logic [10:0] PATTERN_LEN         = 11'd1032;
  localparam logic [10:0] TIME_REF_LEN        = 11'd8;
  localparam logic [5:0]  HEADER_COUNT        = 6'd36;
  localparam logic [2:0]  SELECTOR_MAX        = 3'd6;
  localparam logic [7:0]  COUNT_MAX           = 8'hff;
  localparam logic [7:0]  GS_HDR_READY        = 8'h00;
  localparam logic [7:0]  GS_HDR_BUSY         = 8'h01;
  localparam logic [7:0]  ST_OFF              = 8'h00;
  localparam logic [7:0]  ST_OUTPUT           = 8'h01;
  localparam logic [7:0]  ST_SHUFFLER         = 8'h03;
  localparam logic [7:0]  ST_DEMUX           = 8'h04;
  localparam int          CLK_HZ              = 25_000_000;
  localparam int          TEST_LEAD_MS        = 8;
  localparam int          TEST_LEAD_CYCLES    = CLK_HZ / 1000 * TEST_LEAD_MS;
  localparam int          FRINGE_CYCLES_DEF   = 3_275_000;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } byte_beat_t;

  typedef struct packed {
    logic [2:0] selector;
    logic [1:0] kind;
    logic       broadcast;
  } track_target_t;
endpackage

// >>> hw/deformatter_cmd.sv
// command handler of the deformatter card: status, test and track pass-through
//
// Function
// - model-limit request returns six bytes from three counters
// - model-limit byte counters saturate at ff
// - count time-reference mismatches over four phase centres
// - count model jumps beyond one, clear on read
// - four-byte lost-tic count, lsbyte last, cleared
// - single header index 0-35, thirty bytes
// - single header non-destructive, accepted only for index 0-35
// - track status 72 bytes, non-destructive, anytime
// - special status like general, no header inhibit
// - headers ready halts reading until full request
// - self-test argument selects pattern injection point
// - drive test frame on/off by argument
// - pattern download 1032 bytes, bits s and m
// - test cycle starts at tic, one fringe cycle
// - sync enable sets debug pulse flag
// - error display argument disables display groups
// - start-observe re-enables displays, disables stop counting
// - pass-through carries selector and byte counts
// - track reset consumes dummy byte then resets
// - time reference six-byte count plus day, flag
`timescale 1ns/10ps
`default_nettype none
module deformatter_cmd
  import deformatter_cmd_pkg::*;
#(
  parameter int FRINGE_CYCLES = FRINGE_CYCLES_DEF,
  parameter int DELAY_W       = 16
) (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire byte_beat_t         cmd_in,
  output logic                    cmd_ready,
  output byte_beat_t              rsp_out,
  input  wire logic               tic_pin,
  input  wire logic               sync_lost,
  input  wire logic               model_new,
  input  wire logic [DELAY_W-1:0] model_value,
  input  wire logic [4*DELAY_W-1:0] phase_delay,
  input  wire logic               hdr_all_read,
  input  wire logic [7:0]         hdr_rd_data,
  input  wire logic [7:0]         trk_rd_data,
  input  wire logic [7:0]         pass_rd_data,
  output logic                    hdr_read_enable,
  output logic [10:0]             buf_rd_addr,
  output logic [2:0]              self_test_mode,
  output logic                    drive_test_frame,
  output logic                    pattern_we,
  output logic [10:0]             pattern_addr,
  output logic [1:0]              pattern_bits,
  output logic                    test_cycle_active,
  output logic                    sync_pulse_enable,
  output logic [1:0]              display_disable,
  output track_target_t           track_target,
  output byte_beat_t              track_tx,
  output logic                    track_reset,
  output logic [47:0]             time_ref
);
  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_ARG    = 3'b001,
    S_PASS   = 3'b010,
    S_RESP   = 3'b011,
    S_RET    = 3'b100
  } state_t;

  state_t      state_reg;
  logic [7:0]  func_reg;
  logic [10:0] arg_cnt_reg;
  logic [10:0] resp_cnt_reg;
  logic [15:0] xfer_reg;
  logic [15:0] ret_reg;
  logic [7:0]  resp_next;
  logic        tic_s1_reg;
  logic        tic_s2_reg;
  logic        tic_s3_reg;
  logic        tic_edge;
  logic [7:0]  tref_err_reg;
  logic [7:0]  model_err_reg;
  logic [31:0] lost_reg;
  logic [7:0]  gs_tref_reg;
  logic [7:0]  gs_model_reg;
  logic [DELAY_W-1:0] model_prev_reg;
  logic [4*DELAY_W-1:0] delay_prev_reg;
  logic [47:0] tref_shift_reg;
  logic        test_armed_reg;
  logic [31:0] test_cnt_reg;
  logic [3:0]  ref_mis;
  logic        model_mis;
  logic        tref_done;
  logic        take;

  assign take      = cmd_in.valid && cmd_ready;
  assign tic_edge  = tic_s2_reg && !tic_s3_reg;
  assign tref_done = take && state_reg == S_ARG && func_reg == FC_TIME_REFERENCE
                     && arg_cnt_reg == 11'd1;

  // station tic synchroniser
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tic_s1_reg <= 1'b0;
      tic_s2_reg <= 1'b0;
      tic_s3_reg <= 1'b0;
    end else begin
      tic_s1_reg <= tic_pin;
      tic_s2_reg <= tic_s1_reg;
      tic_s3_reg <= tic_s2_reg;
    end
  end

  // per phase centre comparison of old and new reference plus delay
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_phase
      logic [48:0] sum_old;
      logic [48:0] sum_new;
      logic [48:0] diff;
      assign sum_old = {1'b0, time_ref}
                       + 49'(delay_prev_reg[g*DELAY_W +: DELAY_W]);
      assign sum_new = {1'b0, tref_shift_reg[39:0], cmd_in.data}
                       + 49'(phase_delay[g*DELAY_W +: DELAY_W]);
      assign diff    = (sum_old > sum_new) ? sum_old - sum_new : sum_new - sum_old;
      assign ref_mis[g] = diff > 49'd1;
    end
  endgenerate

  assign model_mis = (model_value > model_prev_reg)
                     ? (model_value - model_prev_reg) > DELAY_W'(1)
                     : (model_prev_reg - model_value) > DELAY_W'(1);

  // command sequencer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg    <= S_IDLE;
      func_reg     <= 8'h00;
      arg_cnt_reg  <= 11'd0;
      resp_cnt_reg <= 11'd0;
      xfer_reg     <= 16'h0000;
      ret_reg      <= 16'h0000;
      cmd_ready    <= 1'b0;
    end else begin
      cmd_ready <= (state_reg != S_RESP) && (state_reg != S_RET);
      case (state_reg)
        S_IDLE: begin
          if (take) begin
            func_reg <= cmd_in.data;
            case (cmd_in.data)
              FC_MODEL_LIMIT: begin
                resp_cnt_reg <= MODEL_LIMIT_LEN;
                state_reg    <= S_RESP;
                cmd_ready    <= 1'b0;
              end
              FC_TRACK_STATUS: begin
                resp_cnt_reg <= TRACK_STATUS_LEN;
                state_reg    <= S_RESP;
                cmd_ready    <= 1'b0;
              end
              FC_GENERAL_STATUS, FC_SPECIAL_STATUS: begin
                resp_cnt_reg <= GENERAL_STATUS_LEN;
                state_reg    <= S_RESP;
                cmd_ready    <= 1'b0;
              end
              FC_SINGLE_HEADER, FC_SELF_TEST, FC_DRIVE_TEST, FC_ERROR_DISPLAY,
              FC_TRACK_RESET: begin
                arg_cnt_reg <= 11'd1;
                state_reg   <= S_ARG;
              end
              FC_PATTERN_LOAD: begin
                arg_cnt_reg <= PATTERN_LEN;
                state_reg   <= S_ARG;
              end
              FC_TIME_REFERENCE: begin
                arg_cnt_reg <= TIME_REF_LEN;
                state_reg   <= S_ARG;
              end
              FC_TRACK_WRITE: begin
                arg_cnt_reg <= 11'd3;
                state_reg   <= S_ARG;
              end
              FC_TRACK_READ: begin
                arg_cnt_reg <= 11'd5;
                state_reg   <= S_ARG;
              end
              default: state_reg <= S_IDLE;
            endcase
          end
        end
        S_ARG: begin
          if (take) begin
            arg_cnt_reg <= arg_cnt_reg - 11'd1;
            if (func_reg == FC_TRACK_WRITE && arg_cnt_reg <= 11'd2)
              xfer_reg <= {xfer_reg[7:0], cmd_in.data};
            if (func_reg == FC_TRACK_READ && (arg_cnt_reg == 11'd4 || arg_cnt_reg == 11'd3))
              xfer_reg <= {xfer_reg[7:0], cmd_in.data};
            if (func_reg == FC_TRACK_READ && arg_cnt_reg <= 11'd2)
              ret_reg <= {ret_reg[7:0], cmd_in.data};
            if (arg_cnt_reg == 11'd1) begin
              if (func_reg == FC_SINGLE_HEADER) begin
                if (cmd_in.data < {2'b00, HEADER_COUNT}) begin
                  resp_cnt_reg <= HEADER_LEN;
                  state_reg    <= S_RESP;
                  cmd_ready    <= 1'b0;
                end else begin
                  state_reg <= S_IDLE;
                end
              end else if (func_reg == FC_TRACK_WRITE) begin
                state_reg <= ({xfer_reg[7:0], cmd_in.data} == 16'h0000) ? S_IDLE : S_PASS;
              end else if (func_reg == FC_TRACK_READ) begin
                if (xfer_reg != 16'h0000) begin
                  state_reg <= S_PASS;
                end else if ({ret_reg[7:0], cmd_in.data} != 16'h0000) begin
                  state_reg <= S_RET;
                  cmd_ready <= 1'b0;
                end else begin
                  state_reg <= S_IDLE;
                end
              end else begin
                state_reg <= S_IDLE;
              end
            end
          end
        end
        S_PASS: begin
          if (take) begin
            xfer_reg <= xfer_reg - 16'h0001;
            if (xfer_reg == 16'h0001) begin
              state_reg <= (func_reg == FC_TRACK_READ && ret_reg != 16'h0000)
                           ? S_RET : S_IDLE;
              cmd_ready <= !(func_reg == FC_TRACK_READ && ret_reg != 16'h0000);
            end
          end
        end
        S_RET: begin
          ret_reg   <= ret_reg - 16'h0001;
          cmd_ready <= 1'b0;
          if (ret_reg <= 16'h0001) begin
            state_reg <= S_IDLE;
            cmd_ready <= 1'b1;
          end
        end
        S_RESP: begin
          resp_cnt_reg <= resp_cnt_reg - 11'd1;
          cmd_ready    <= 1'b0;
          if (resp_cnt_reg == 11'd1) begin
            state_reg <= S_IDLE;
            cmd_ready <= 1'b1;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // response byte selection
  always_comb begin
    resp_next = 8'h00;
    case (func_reg)
      FC_MODEL_LIMIT: begin
        case (resp_cnt_reg)
          11'd6:   resp_next = tref_err_reg;
          11'd5:   resp_next = model_err_reg;
          11'd4:   resp_next = lost_reg[31:24];
          11'd3:   resp_next = lost_reg[23:16];
          11'd2:   resp_next = lost_reg[15:8];
          default: resp_next = lost_reg[7:0];
        endcase
      end
      FC_GENERAL_STATUS, FC_SPECIAL_STATUS: begin
        case (resp_cnt_reg)
          11'd7:   resp_next = hdr_all_read ? GS_HDR_READY : GS_HDR_BUSY;
          11'd4:   resp_next = gs_tref_reg;
          11'd3:   resp_next = gs_model_reg;
          default: resp_next = 8'h00;
        endcase
      end
      FC_SINGLE_HEADER: resp_next = hdr_rd_data;
      FC_TRACK_STATUS:  resp_next = trk_rd_data;
      FC_TRACK_READ:    resp_next = pass_rd_data;
      default:          resp_next = 8'h00;
    endcase
  end

  // response stream and buffer addressing
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rsp_out     <= '0;
      buf_rd_addr <= 11'd0;
    end else begin
      rsp_out.valid <= (state_reg == S_RESP) || (state_reg == S_RET);
      rsp_out.data  <= (state_reg == S_RESP || state_reg == S_RET) ? resp_next : 8'h00;
      if (state_reg == S_ARG && func_reg == FC_SINGLE_HEADER && take)
        buf_rd_addr <= 11'(cmd_in.data) * HEADER_LEN;
      else if (state_reg == S_IDLE && take && cmd_in.data == FC_TRACK_STATUS)
        buf_rd_addr <= 11'd0;
      else if (state_reg == S_RESP || state_reg == S_RET)
        buf_rd_addr <= buf_rd_addr + 11'd1;
    end
  end

  // error counters, saturating, cleared by the reading request; set wins over clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tref_err_reg   <= 8'h00;
      model_err_reg  <= 8'h00;
      gs_tref_reg    <= 8'h00;
      gs_model_reg   <= 8'h00;
      lost_reg       <= 32'h0;
      model_prev_reg <= '0;
      delay_prev_reg <= '0;
    end else begin
      if (state_reg == S_RESP && resp_cnt_reg == 11'd1 && func_reg == FC_MODEL_LIMIT) begin
        tref_err_reg  <= 8'h00;
        model_err_reg <= 8'h00;
        lost_reg      <= 32'h0;
      end
      if (state_reg == S_RESP && resp_cnt_reg == 11'd1 && (func_reg == FC_GENERAL_STATUS ||
          func_reg == FC_SPECIAL_STATUS)) begin
        gs_tref_reg  <= 8'h00;
        gs_model_reg <= 8'h00;
      end
      if (tref_done) begin
        delay_prev_reg <= phase_delay;
        if (|ref_mis && !display_disable[0]) begin
          if (tref_err_reg != COUNT_MAX) tref_err_reg <= tref_err_reg + 8'h01;
          if (gs_tref_reg != COUNT_MAX)  gs_tref_reg  <= gs_tref_reg + 8'h01;
        end
      end
      if (model_new) begin
        model_prev_reg <= model_value;
        if (model_mis && !display_disable[1]) begin
          if (model_err_reg != COUNT_MAX) model_err_reg <= model_err_reg + 8'h01;
          if (gs_model_reg != COUNT_MAX)  gs_model_reg  <= gs_model_reg + 8'h01;
        end
      end
      if (sync_lost && lost_reg != 32'hffffffff)
        lost_reg <= lost_reg + 32'h1;
    end
  end

  // header read inhibit handshake
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hdr_read_enable <= 1'b1;
    end else if (take && state_reg == S_IDLE && cmd_in.data == FC_HEADER_REQUEST) begin
      hdr_read_enable <= 1'b1;
    end else if (state_reg == S_RESP && func_reg == FC_GENERAL_STATUS && hdr_all_read) begin
      hdr_read_enable <= 1'b0;
    end
  end

  // test and display control settings
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      self_test_mode    <= 3'b000;
      drive_test_frame  <= 1'b0;
      sync_pulse_enable <= 1'b0;
      display_disable   <= 2'b00;
      track_reset       <= 1'b0;
      time_ref          <= 48'h0;
      tref_shift_reg    <= 48'h0;
    end else begin
      track_reset <= 1'b0;
      if (take && state_reg == S_IDLE && cmd_in.data == FC_START_OBSERVE)
        display_disable <= 2'b00;
      if (take && state_reg == S_IDLE && cmd_in.data == FC_SYNC_ENABLE)
        sync_pulse_enable <= 1'b1;
      if (take && state_reg == S_ARG) begin
        tref_shift_reg <= {tref_shift_reg[39:0], cmd_in.data};
        if (arg_cnt_reg == 11'd1) begin
          case (func_reg)
            FC_SELF_TEST: begin
              case (cmd_in.data)
                ST_OFF:      self_test_mode <= 3'b000;
                ST_OUTPUT:   self_test_mode <= 3'b001;
                ST_SHUFFLER: self_test_mode <= 3'b010;
                ST_DEMUX:    self_test_mode <= 3'b100;
                default:     self_test_mode <= self_test_mode;
              endcase
            end
            FC_DRIVE_TEST:    drive_test_frame <= cmd_in.data[0];
            FC_ERROR_DISPLAY: display_disable  <= cmd_in.data[1:0];
            FC_TRACK_RESET:   track_reset      <= 1'b1;
            FC_TIME_REFERENCE: time_ref <= {tref_shift_reg[39:0], cmd_in.data};
            default: ;
          endcase
        end
      end
    end
  end

  // pattern download and pass-through byte forwarding
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pattern_we   <= 1'b0;
      pattern_addr <= 11'd0;
      pattern_bits <= 2'b00;
      track_tx     <= '0;
      track_target <= '0;
    end else begin
      pattern_we     <= take && state_reg == S_ARG && func_reg == FC_PATTERN_LOAD;
      track_tx.valid <= take && state_reg == S_PASS;
      track_tx.data  <= cmd_in.data;
      if (take && state_reg == S_ARG && func_reg == FC_PATTERN_LOAD) begin
        pattern_addr <= PATTERN_LEN - arg_cnt_reg;
        pattern_bits <= {cmd_in.data[1], cmd_in.data[0]};
      end
      if (take && state_reg == S_IDLE)
        track_target.kind <= (cmd_in.data == FC_TRACK_READ) ? 2'b01 : 2'b00;
      if (take && state_reg == S_ARG && arg_cnt_reg >= 11'd3 &&
          (func_reg == FC_TRACK_WRITE ? arg_cnt_reg == 11'd3 : arg_cnt_reg == 11'd5)) begin
        track_target.selector  <= (cmd_in.data[2:0] > SELECTOR_MAX) ? SELECTOR_MAX
                                  : cmd_in.data[2:0];
        track_target.broadcast <= cmd_in.data[2];
      end
    end
  end

  // test cycle: armed by command, runs from next tic for one fringe cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      test_armed_reg    <= 1'b0;
      test_cnt_reg      <= 32'h0;
      test_cycle_active <= 1'b0;
    end else begin
      if (take && state_reg == S_IDLE && cmd_in.data == FC_TEST_CYCLE)
        test_armed_reg <= 1'b1;
      if (tic_edge && test_armed_reg) begin
        test_armed_reg    <= 1'b0;
        test_cycle_active <= 1'b1;
        test_cnt_reg      <= 32'(FRINGE_CYCLES - 1);
      end else if (test_cycle_active) begin
        test_cnt_reg <= test_cnt_reg - 32'h1;
        if (test_cnt_reg == 32'h0)
          test_cycle_active <= 1'b0;
      end
    end
  end

  a_lost_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_reg == S_RESP && func_reg == FC_MODEL_LIMIT && resp_cnt_reg == 11'd1 && !sync_lost)
    |=> lost_reg == 32'h0) else $error("lost count not cleared");
  a_err_saturate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    model_err_reg == COUNT_MAX && !(state_reg == S_RESP && func_reg == FC_MODEL_LIMIT)
    |=> model_err_reg == COUNT_MAX) else $error("counter wrapped");
  a_display_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (take && state_reg == S_IDLE && cmd_in.data == FC_START_OBSERVE) |=> display_disable == 2'b00)
    else $error("display not re-enabled");
  a_test_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(test_cycle_active) |-> $past(tic_edge)) else $error("test cycle not on tic");
  a_model_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (take && state_reg == S_IDLE && cmd_in.data == FC_MODEL_LIMIT)
    |=> !rsp_out.valid ##1 rsp_out.valid [*6] ##1 !rsp_out.valid) else $error("model length wrong");
  a_header_arg: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (take && state_reg == S_ARG && func_reg == FC_SINGLE_HEADER && cmd_in.data > 8'd35)
    |=> state_reg == S_IDLE) else $error("bad header index accepted");
  a_drive_frame: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (take && state_reg == S_ARG && func_reg == FC_DRIVE_TEST && arg_cnt_reg == 11'd1)
    |=> drive_test_frame == $past(cmd_in.data[0])) else $error("drive test not set");
  a_reset_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    track_reset |=> !track_reset) else $error("reset pulse too long");
endmodule
`default_nettype wire

// >>> testbench/host_model.sv
// host side of the control bus: sends queued bytes under the ready handshake
`timescale 1ns/10ps
`default_nettype none
module host_model
  import deformatter_cmd_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic cmd_ready,
  output byte_beat_t cmd_in
);
  logic [7:0] q[$];
  initial cmd_in = '0;
  // byte held until taken; idle data toggles so stale values never match
  always @(posedge sys_clk) begin
    if (!rst_n) cmd_in <= '0;
    else if (!cmd_in.valid || cmd_ready) begin
      if (q.size() > 0) cmd_in <= '{data: q.pop_front(), valid: 1'b1};
      else cmd_in <= '{data: ~cmd_in.data, valid: 1'b0};
    end
  end
endmodule
`default_nettype wire

// >>> testbench/deformatter_cmd_tb.sv
// self-checking bench for the deformatter command handler
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module deformatter_cmd_tb
  import deformatter_cmd_pkg::*;
;
  logic sys_clk, rst_n, tic_pin, sync_lost, model_new, hdr_all_read, cmd_ready, hdr_read_enable;
  logic pattern_we, sync_pulse_enable, drive_test_frame, track_reset, test_cycle_active;
  int active_cycles;
  logic [15:0] model_value;
  logic [63:0] phase_delay;
  logic [7:0] hdr_d, trk_d, pass_d, got, b;
  logic [2:0] self_test_mode;
  logic [1:0] display_disable, pattern_bits;
  logic [47:0] time_ref;
  byte_beat_t cmd_in, rsp_out, track_tx;
  track_target_t track_target;
  logic [7:0] exp_q[$], pat_q[$], tx_q[$];
  logic [7:0] st_arg[4] = '{ST_OUTPUT, ST_SHUFFLER, ST_DEMUX, ST_OFF};
  logic [2:0] st_mode[4] = '{3'b001, 3'b010, 3'b100, 3'b000};
  int mismatches, compares, resets, i, seed = 48232;
  host_model host (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_ready(cmd_ready), .cmd_in(cmd_in));
  deformatter_cmd #(.FRINGE_CYCLES(20)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_in(cmd_in),
    .cmd_ready(cmd_ready), .rsp_out(rsp_out), .tic_pin(tic_pin), .sync_lost(sync_lost),
    .model_new(model_new), .model_value(model_value), .phase_delay(phase_delay),
    .hdr_all_read(hdr_all_read), .hdr_rd_data(hdr_d), .trk_rd_data(trk_d), .pass_rd_data(pass_d),
    .hdr_read_enable(hdr_read_enable), .buf_rd_addr(), .self_test_mode(self_test_mode),
    .drive_test_frame(drive_test_frame), .pattern_we(pattern_we), .pattern_addr(),
    .pattern_bits(pattern_bits), .test_cycle_active(test_cycle_active),
    .sync_pulse_enable(sync_pulse_enable),
    .display_disable(display_disable), .track_target(track_target), .track_tx(track_tx),
    .track_reset(track_reset), .time_ref(time_ref));
  task send(input logic [7:0] v[]);
    foreach (v[k]) host.q.push_back(v[k]);
  endtask
  task ex(input logic [7:0] v[]);
    foreach (v[k]) exp_q.push_back(v[k]);
  endtask
  task go;
    int n;
    n = 0;
    while ((host.q.size() != 0 || exp_q.size() != 0 || cmd_ready !== 1'b1) && n < 5000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 5000) begin
      mismatches++;
      $display("ERROR %0t: command stalled", $time);
    end
    repeat (3) @(posedge sys_clk);
  endtask
  task jump(input logic [15:0] v);
    model_value <= v;
    model_new <= 1'b1;
    @(posedge sys_clk);
    model_new <= 1'b0;
    @(posedge sys_clk);
  endtask
  task end_of_test;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) if (rst_n) begin
    if (rsp_out.valid === 1'b1) begin
      got = exp_q.pop_front();
      `CHK(rsp_out.data, got)
    end
    if (pattern_we === 1'b1) begin
      got = pat_q.pop_front();
      `CHK(pattern_bits, got[1:0])
    end
    if (track_tx.valid === 1'b1) begin
      got = tx_q.pop_front();
      `CHK(track_tx.data, got)
    end
    if (track_reset === 1'b1) resets++;
    if (test_cycle_active === 1'b1) active_cycles++;
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    $display("ERROR %0t: timeout", $time);
    end_of_test;
  end
  initial begin
    rst_n = 1'b0; tic_pin = 1'b0; sync_lost = 1'b0; model_new = 1'b0; model_value = '0;
    phase_delay = '0; hdr_all_read = 1'b1;
    hdr_d = $random(seed); trk_d = $random(seed); pass_d = $random(seed);
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    ex('{0, 0, 0, 0, 0, 0, 0}); send('{FC_SPECIAL_STATUS}); go;
    `CHK(hdr_read_enable, 1'b1)
    ex('{0, 0, 0, 0, 0, 0, 0}); send('{FC_GENERAL_STATUS}); go;
    `CHK(hdr_read_enable, 1'b0)
    send('{FC_HEADER_REQUEST}); go;
    `CHK(hdr_read_enable, 1'b1)
    for (i = 0; i < 30; i++) ex('{hdr_d});
    send('{FC_SINGLE_HEADER, 8'd35, FC_SINGLE_HEADER, 8'd36}); go;
    for (i = 0; i < 72; i++) ex('{trk_d});
    send('{FC_TRACK_STATUS}); go;
    hdr_all_read <= 1'b0;
    jump(16'h0001); jump(16'h0010); jump(16'h000e);
    send('{FC_TIME_REFERENCE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05}); go;
    `CHK(time_ref, 48'h5)
    repeat (3) begin sync_lost <= 1'b1; @(posedge sys_clk); sync_lost <= 1'b0; @(posedge sys_clk); end
    ex('{1, 2, 0, 0, 0, 3}); send('{FC_MODEL_LIMIT}); go;
    ex('{1, 0, 0, 1, 2, 0, 0}); send('{FC_GENERAL_STATUS}); go;
    for (i = 0; i < 300; i++) jump(i[0] ? 16'h0010 : 16'h0000);
    ex('{0, 8'hff, 0, 0, 0, 0}); send('{FC_MODEL_LIMIT}); go;
    for (i = 0; i < 4; i++) begin
      send('{FC_SELF_TEST, st_arg[i]}); go;
      `CHK(self_test_mode, st_mode[i])
      send('{FC_DRIVE_TEST, 8'(i % 2)}); go;
      `CHK(drive_test_frame, i[0])
      send('{FC_ERROR_DISPLAY, 8'(i)}); go;
      `CHK(display_disable, i[1:0])
    end
    jump(16'h0040); jump(16'h0000);
    send('{FC_START_OBSERVE, FC_SYNC_ENABLE}); go;
    `CHK(display_disable, 2'b00)
    `CHK(sync_pulse_enable, 1'b1)
    ex('{0, 0, 0, 0, 0, 0}); send('{FC_MODEL_LIMIT}); go;
    send('{FC_PATTERN_LOAD});
    for (i = 0; i < 1032; i++) begin b = $random(seed); pat_q.push_back(b); send('{b}); end
    go;
    `CHK(pat_q.size(), 0)
    send('{FC_TEST_CYCLE}); go; // command sent well before the tic
    tic_pin <= 1'b1; repeat (4) @(posedge sys_clk); tic_pin <= 1'b0;
    repeat (30) @(posedge sys_clk);
    `CHK(active_cycles, 20)
    send('{FC_TRACK_RESET, 8'h82}); go;
    `CHK(resets, 1)
    tx_q = '{8'ha1, 8'hb2, 8'hc3};
    send('{FC_TRACK_WRITE, 8'h06, 8'h00, 8'h03, 8'ha1, 8'hb2, 8'hc3}); go; // not observing
    `CHK(track_target.selector, 3'd6)
    tx_q = '{8'h5e}; ex('{pass_d, pass_d});
    send('{FC_TRACK_READ, 8'h02, 8'h00, 8'h01, 8'h00, 8'h02, 8'h5e}); go;
    `CHK(track_target.selector, 3'd2)
    `CHK(tx_q.size(), 0)
    end_of_test;
  end
endmodule
`default_nettype wire
